// File: core/dic_pkg.sv
// Package with register map, field layout, reset values and timing for input conditioning
package dic_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned CYCLE_US        = 5000;
    localparam int unsigned CYCLE_CLKS      = CLK_HZ / 1_000_000 * CYCLE_US;
    localparam int unsigned MS_US           = 1000;
    localparam int unsigned AC_EXTRA_MS     = 30;
    localparam int unsigned NUM_IN          = 8;
    localparam int unsigned NUM_OUT         = 5;
    // Register byte offsets; per-channel block of 8 words at 0x100 + 0x20*n
    localparam logic [11:0] REG_OUT_CTRL    = 12'h000;
    localparam logic [11:0] REG_STATUS      = 12'h004;
    localparam logic [11:0] REG_OUT_STATE   = 12'h008;
    localparam logic [11:0] REG_CH_BASE     = 12'h100;
    localparam int unsigned CH_SHIFT        = 5;
    localparam logic [2:0]  CH_CFG          = 3'h0;
    localparam logic [2:0]  CH_ACT_THR      = 3'h1;
    localparam logic [2:0]  CH_REL_THR      = 3'h2;
    localparam logic [2:0]  CH_ACT_DLY      = 3'h3;
    localparam logic [2:0]  CH_DROP_DLY     = 3'h4;
    localparam logic [2:0]  CH_COUNT        = 3'h5;
    localparam logic [2:0]  CH_VOLT         = 3'h6;
    // Config register fields
    localparam int unsigned CFG_POL_NC_BIT  = 0;
    localparam int unsigned CFG_AC_BIT      = 1;
    localparam int unsigned CFG_CLR_BIT     = 8;
    // Thresholds in 0.1 V units; voltage in mV; delays in ms
    localparam logic [11:0] ACT_THR_RST     = 12'h370;
    localparam logic [11:0] REL_THR_RST     = 12'h258;
    localparam logic [20:0] DLY_RST         = 21'h00_0000;
    localparam logic [31:0] CNT_RST         = 32'h0000_0000;
    localparam logic [31:0] SLVERR_DATA     = 32'h0000_0000;
endpackage

// File: core/dic_chan.sv
// One conditioned input channel: hysteresis, polarity, delays and transition counter
`timescale 1ns/100ps
module dic_chan
    import dic_pkg::*;
(
    input  wire logic        pclk,       // Clock
    input  wire logic        presetn,    // Async reset, active low
    input  wire logic        tick,       // One-cycle 5 ms program tick
    input  wire logic        ms_tick,    // One-cycle 1 ms tick
    input  wire logic [17:0] volt_mv,    // Synchronised voltage in mV
    input  wire logic        pol_nc,     // Normally closed polarity
    input  wire logic        ac_mode,    // AC mode enable
    input  wire logic [11:0] act_thr,    // Activation threshold, 0.1 V
    input  wire logic [11:0] rel_thr,    // Release threshold, 0.1 V
    input  wire logic [20:0] act_dly,    // Activation delay, ms
    input  wire logic [20:0] drop_dly,   // Drop-off time, ms
    input  wire logic        clr_cnt,    // Clear counter pulse
    output logic             status,     // Conditioned status
    output logic [31:0]      count       // Count of 0-to-1 transitions
);
    logic        raw_r;
    logic        status_r;
    logic [21:0] dly_r;
    logic [19:0] act_mv;
    logic [19:0] rel_mv;
    logic [21:0] target;
    logic        energ_hi;
    logic        energ_lo;
    logic        want;

    // 0.1 V units to mV; 20 bits so a full-scale 12-bit threshold cannot wrap
    assign act_mv = 20'(act_thr) * 20'h0_0064;
    assign rel_mv = ac_mode ? 20'(act_thr) * 20'h0_000A : 20'(rel_thr) * 20'h0_0064;
    assign energ_hi = {2'b00, volt_mv} > act_mv;
    assign energ_lo = {2'b00, volt_mv} < rel_mv;

    // Raw energised state, held inside the band; sampled on the program tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            raw_r <= 1'b0;
        else if (tick && energ_hi)
            raw_r <= 1'b1;
        else if (tick && energ_lo)
            raw_r <= 1'b0;
    end

    assign want = raw_r ^ pol_nc;
    assign target = want ? 22'(act_dly)
                         : 22'(drop_dly) + (ac_mode ? 22'(AC_EXTRA_MS) : 22'd0);

    // Delay counts whole ms while the wanted state differs; a reversal restarts it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_r <= 1'b0;
            dly_r    <= 22'd0;
        end
        else if (want == status_r)
            dly_r <= 22'd0;
        else if (dly_r >= target)
        begin
            status_r <= want;
            dly_r    <= 22'd0;
        end
        else if (ms_tick)
            dly_r <= dly_r + 22'd1;
    end

    // Counter: a rising edge in the clear cycle still counts, as 1
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= CNT_RST;
        else if (clr_cnt)
            count <= (want && !status_r && dly_r >= target) ? 32'd1 : CNT_RST;
        else if (want && !status_r && dly_r >= target)
            count <= count + 32'd1;
    end

    assign status = status_r;
endmodule

// File: core/dic_top.sv
// APB slave with per-channel input conditioning and five cycle-refreshed outputs
`timescale 1ns/100ps
module dic_top
    import dic_pkg::*;
#(
    parameter int unsigned N_IN       = NUM_IN,
    parameter int unsigned N_OUT      = NUM_OUT,
    parameter int unsigned CYC_CLKS   = CYCLE_CLKS,
    parameter int unsigned MS_CLKS    = CLK_HZ / 1_000_000 * MS_US
)
(
    input  wire logic                 pclk,        // APB clock, 25 MHz
    input  wire logic                 presetn,     // Async reset, active low
    input  wire logic                 psel,        // APB select
    input  wire logic                 penable,     // APB enable
    input  wire logic                 pwrite,      // APB write
    input  wire logic [11:0]          paddr,       // APB byte address
    input  wire logic [31:0]          pwdata,      // APB write data
    input  wire logic [3:0]           pstrb,       // APB byte strobes
    output logic                      pready,      // APB ready
    output logic [31:0]               prdata,      // APB read data
    output logic                      pslverr,     // APB error
    input  wire logic [N_IN*18-1:0]   volt_in,     // Measured voltages in mV, from the ADC domain
    output logic [N_IN-1:0]           input_status, // Conditioned statuses
    output logic [N_OUT-1:0]          output_channel_n, // Output drives
    output logic                      cycle_tick   // 5 ms program cycle pulse
);
    logic [31:0]            cyc_r;
    logic [31:0]            ms_r;
    logic                   tick;
    logic                   ms_tick;
    logic [N_OUT-1:0]       out_ctrl_r;
    logic [N_OUT-1:0]       out_r;
    logic [N_IN*18-1:0]     volt_s1_r;
    logic [N_IN*18-1:0]     volt_s2_r;
    logic [N_IN-1:0]        pol_nc_r;
    logic [N_IN-1:0]        ac_r;
    logic [N_IN-1:0]        clr_r;
    logic [11:0]            act_thr_r  [N_IN];
    logic [11:0]            rel_thr_r  [N_IN];
    logic [20:0]            act_dly_r  [N_IN];
    logic [20:0]            drop_dly_r [N_IN];
    logic [31:0]            cnt_w      [N_IN];
    logic                   wr_en;
    logic                   rd_en;
    logic                   is_ch;
    logic [2:0]             ch_idx;
    logic [2:0]             ch_reg;
    logic                   hit;
    logic [31:0]            rd_val;
    logic [31:0]            wmask;

    // Program cycle and millisecond timers
    assign tick    = (cyc_r == 32'(CYC_CLKS - 1));
    assign ms_tick = (ms_r  == 32'(MS_CLKS - 1));
    assign cycle_tick = tick;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cyc_r <= 32'd0;
        else if (tick)
            cyc_r <= 32'd0;
        else
            cyc_r <= cyc_r + 32'd1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ms_r <= 32'd0;
        else if (ms_tick)
            ms_r <= 32'd0;
        else
            ms_r <= ms_r + 32'd1;
    end

    // Voltage words come from another domain; two flops before use.
    // Limitation: a multi-bit word may tear on a change; the source must hold it stable.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            volt_s1_r <= '0;
            volt_s2_r <= '0;
        end
        else
        begin
            volt_s1_r <= volt_in;
            volt_s2_r <= volt_s1_r;
        end
    end

    // APB decode: zero-wait slave, access completes in the enable cycle
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && !penable && !pwrite;
    // Compared at 32 bits: a channel count of 8 does not fit the 3-bit index
    assign is_ch  = (paddr[11:8] == REG_CH_BASE[11:8]) && (32'(paddr[7:CH_SHIFT]) < N_IN);
    assign ch_idx = paddr[7:CH_SHIFT];
    assign ch_reg = paddr[4:2];
    assign wmask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_comb
    begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr[1:0] != 2'b00)
            hit = 1'b0;
        else if (paddr == REG_OUT_CTRL)
            rd_val = 32'(out_ctrl_r);
        else if (paddr == REG_STATUS)
            rd_val = 32'(input_status);
        else if (paddr == REG_OUT_STATE)
            rd_val = 32'(out_r);
        else if (is_ch)
        begin
            unique case (ch_reg)
                CH_CFG:      rd_val = {30'd0, ac_r[ch_idx], pol_nc_r[ch_idx]};
                CH_ACT_THR:  rd_val = 32'(act_thr_r[ch_idx]);
                CH_REL_THR:  rd_val = 32'(rel_thr_r[ch_idx]);
                CH_ACT_DLY:  rd_val = 32'(act_dly_r[ch_idx]);
                CH_DROP_DLY: rd_val = 32'(drop_dly_r[ch_idx]);
                CH_COUNT:    rd_val = cnt_w[ch_idx];
                CH_VOLT:     rd_val = 32'(volt_s2_r[ch_idx*18 +: 18]);
                default:     hit = 1'b0;
            endcase
        end
        else
            hit = 1'b0;
    end

    // Read data registered in the setup cycle so it is ready in the enable cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
            prdata <= hit ? rd_val : SLVERR_DATA;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else if (psel && !penable)
            pslverr <= !hit;
    end

    // Output control register, applied to the drives only at the cycle tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_ctrl_r <= '0;
        else if (wr_en && paddr == REG_OUT_CTRL)
            out_ctrl_r <= (out_ctrl_r & ~wmask[N_OUT-1:0]) | (pwdata[N_OUT-1:0] & wmask[N_OUT-1:0]);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_r <= '0;
        else if (tick)
            out_r <= out_ctrl_r;
    end
    assign output_channel_n = out_r;

    genvar g;
    generate
        for (g = 0; g < N_IN; g++)
        begin : g_ch
            logic ch_wr;
            // Misaligned or unmapped addresses are refused, so they must not write
            assign ch_wr = wr_en && hit && is_ch && (ch_idx == 3'(g));

            // Per-channel settings; each channel owns its thresholds
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pol_nc_r[g]   <= 1'b0;
                    ac_r[g]       <= 1'b0;
                    act_thr_r[g]  <= ACT_THR_RST;
                    rel_thr_r[g]  <= REL_THR_RST;
                    act_dly_r[g]  <= DLY_RST;
                    drop_dly_r[g] <= DLY_RST;
                end
                else if (ch_wr)
                begin
                    unique case (ch_reg)
                        CH_CFG:
                        begin
                            if (pstrb[0])
                            begin
                                pol_nc_r[g] <= pwdata[CFG_POL_NC_BIT];
                                ac_r[g]     <= pwdata[CFG_AC_BIT];
                            end
                        end
                        CH_ACT_THR:  act_thr_r[g]  <= pwdata[11:0];
                        CH_REL_THR:  rel_thr_r[g]  <= pwdata[11:0];
                        CH_ACT_DLY:  act_dly_r[g]  <= pwdata[20:0];
                        CH_DROP_DLY: drop_dly_r[g] <= pwdata[20:0];
                        default:     ;
                    endcase
                end
            end

            // Clear command is a self-clearing pulse from the config write
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    clr_r[g] <= 1'b0;
                else
                    clr_r[g] <= ch_wr && (ch_reg == CH_CFG) && pstrb[1] && pwdata[CFG_CLR_BIT];
            end

            dic_chan u_chan
            (
                .pclk     (pclk),
                .presetn  (presetn),
                .tick     (tick),
                .ms_tick  (ms_tick),
                .volt_mv  (volt_s2_r[g*18 +: 18]),
                .pol_nc   (pol_nc_r[g]),
                .ac_mode  (ac_r[g]),
                .act_thr  (act_thr_r[g]),
                .rel_thr  (rel_thr_r[g]),
                .act_dly  (act_dly_r[g]),
                .drop_dly (drop_dly_r[g]),
                .clr_cnt  (clr_r[g]),
                .status   (input_status[g]),
                .count    (cnt_w[g])
            );
        end
    endgenerate
endmodule

// File: tb/dic_chk.sv
// Concurrent checks on the ports of the input conditioning top
`timescale 1ns/100ps
module dic_chk
    import dic_pkg::*;
#(
    parameter int unsigned N_IN     = NUM_IN,
    parameter int unsigned N_OUT    = NUM_OUT,
    parameter int unsigned CYC_CLKS = CYCLE_CLKS
)
(
    input wire logic             pclk,             // Clock
    input wire logic             presetn,          // Async reset, active low
    input wire logic             psel,             // APB select
    input wire logic             penable,          // APB enable
    input wire logic             pwrite,           // APB write
    input wire logic [11:0]      paddr,            // APB address
    input wire logic [31:0]      pwdata,           // APB write data
    input wire logic [3:0]       pstrb,            // APB strobes
    input wire logic             pready,           // APB ready
    input wire logic [31:0]      prdata,           // APB read data
    input wire logic             pslverr,          // APB error
    input wire logic [N_IN-1:0]  input_status,     // Statuses
    input wire logic [N_OUT-1:0] output_channel_n, // Output drives
    input wire logic             cycle_tick        // Cycle pulse
);
    logic [31:0]      cnt_r;
    logic             seen_r;
    logic [N_OUT-1:0] ctl_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Shadow of the output control word, written only on a completed access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctl_r <= '0;
        else if (psel && penable && pwrite && pready && paddr == REG_OUT_CTRL && pstrb[0])
            ctl_r <= pwdata[N_OUT-1:0];
    end

    // Clocks since the last cycle pulse; the first pulse has no reference
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r  <= '0;
            seen_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cycle_tick ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
            seen_r <= seen_r | cycle_tick;
        end
    end

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_s(a);
        setup_s ##0 (!pwrite && paddr == a);
    endsequence

    ready_high_a: assert property (pready) else $error("pready low");
    tick_period_a: assert property (cycle_tick && seen_r |-> cnt_r == CYC_CLKS - 1)
        else $error("cycle pulse spacing wrong");
    out_hold_a: assert property (!$past(cycle_tick) |-> $stable(output_channel_n))
        else $error("outputs changed off cycle");
    out_load_a: assert property (cycle_tick |=> output_channel_n == $past(ctl_r))
        else $error("outputs not loaded from control");
    stat_read_a: assert property (rd_s(REG_STATUS) |=> prdata == 32'($past(input_status)))
        else $error("status read wrong");
    outst_read_a: assert property (rd_s(REG_OUT_STATE) |=> prdata == 32'($past(output_channel_n)))
        else $error("output state read wrong");
    // A refused write leaves read data as it was; only a refused read zeroes it
    gap_err_a: assert property (setup_s ##0 paddr == 12'h11C |=> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    map_ok_a: assert property (setup_s ##0 paddr == REG_STATUS |=> !pslverr)
        else $error("mapped access refused");
endmodule

bind dic_top dic_chk #(.N_IN(N_IN), .N_OUT(N_OUT), .CYC_CLKS(CYC_CLKS)) dic_chk_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .input_status,
    .output_channel_n, .cycle_tick);

// File: tb/digital_input_conditioning_tb_top.sv
// Self-checking bench for the input conditioning block
`timescale 1ns/100ps
module digital_input_conditioning_tb_top;
    import dic_pkg::*;
    localparam int unsigned CYC = 50;
    localparam int unsigned MSC = 10;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, cycle_tick, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [3:0]   pstrb;
    logic [143:0] volt_in;
    logic [7:0]   input_status;
    logic [4:0]   output_channel_n;
    int           mismatches, checks, cyc;

    dic_top #(.CYC_CLKS(CYC), .MS_CLKS(MSC)) dic_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .volt_in, .input_status, .output_channel_n,
        .cycle_tick);

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    // Setup, access, then hold until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the bench timeout ends a hung access
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask

    function automatic logic [11:0] ca(input int ch, input logic [2:0] r);
        return REG_CH_BASE + {4'h0, 3'(ch), r, 2'b00};
    endfunction

    task automatic setv(input int ch, input logic [17:0] mv);
        @(posedge pclk);
        volt_in[ch*18 +: 18] <= mv;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic sts(input int ch, input logic e);
        chk(32'(input_status[ch]), 32'(e));
    endtask

    task automatic t_reset();
        for (int c = 0; c < 8; c++)
        begin
            rdc(ca(c, CH_CFG), 32'h0000_0000);
            rdc(ca(c, CH_ACT_THR), 32'h0000_0370);
            rdc(ca(c, CH_REL_THR), 32'h0000_0258);
            rdc(ca(c, CH_ACT_DLY), 32'h0000_0000);
            rdc(ca(c, CH_DROP_DLY), 32'h0000_0000);
            rdc(ca(c, CH_COUNT), 32'h0000_0000);
        end
        rdc(12'h11C, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        rdc(12'h005, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
    endtask

    task automatic t_no();
        setv(0, 18'h1_5BA8);
        waitc(2*CYC+5);
        sts(0, 1'b1);
        rdc(ca(0, CH_VOLT), 32'h0001_5BA8);
        setv(0, 18'h1_1170);
        waitc(2*CYC+5);
        sts(0, 1'b1);
        setv(0, 18'h0_E678);
        waitc(2*CYC+5);
        sts(0, 1'b0);
        setv(0, 18'h1_57C0);
        waitc(2*CYC+5);
        sts(0, 1'b0);
        setv(0, 18'h1_57C1);
        waitc(2*CYC+5);
        rdc(ca(0, CH_COUNT), 32'h0000_0002);
        apb(1'b1, ca(0, CH_CFG), 32'h0000_0100);
        waitc(3);
        rdc(ca(0, CH_COUNT), 32'h0000_0000);
        rdc(ca(0, CH_CFG), 32'h0000_0000);
    endtask

    task automatic t_nc_thr();
        apb(1'b1, ca(1, CH_CFG), 32'h0000_0001);
        apb(1'b1, ca(2, CH_ACT_THR), 32'h0000_01F4);
        setv(2, 18'h0_EA60);
        setv(3, 18'h0_EA60);
        waitc(2*CYC+5);
        sts(1, 1'b1);
        sts(2, 1'b1);
        sts(3, 1'b0);
        setv(1, 18'h1_5BA8);
        waitc(2*CYC+5);
        sts(1, 1'b0);
    endtask

    task automatic t_dly();
        apb(1'b1, ca(4, CH_ACT_DLY), 32'h0000_0014);
        apb(1'b1, ca(4, CH_DROP_DLY), 32'h0000_0014);
        setv(4, 18'h1_5BA8);
        waitc(100);
        sts(4, 1'b0);
        waitc(200);
        sts(4, 1'b1);
        setv(4, 18'h0_0000);
        waitc(100);
        sts(4, 1'b1);
        waitc(200);
        sts(4, 1'b0);
    endtask

    task automatic t_ac();
        apb(1'b1, ca(5, CH_CFG), 32'h0000_0002);
        setv(5, 18'h1_5BA8);
        waitc(2*CYC+5);
        sts(5, 1'b1);
        setv(5, 18'h0_2710);
        waitc(2*CYC+5);
        sts(5, 1'b1);
        setv(5, 18'h0_1388);
        waitc(200);
        sts(5, 1'b1);
        waitc(200);
        sts(5, 1'b0);
    endtask

    task automatic t_out();
        apb(1'b1, REG_OUT_CTRL, 32'h0000_0015);
        // A missing cycle pulse is caught by the bench timeout
        do
            @(negedge pclk);
        while (cycle_tick !== 1'b1);
        chk(32'(output_channel_n), 32'h0000_0000);
        waitc(1);
        chk(32'(output_channel_n), 32'h0000_0015);
        rdc(REG_OUT_STATE, 32'h0000_0015);
        // Channels 0 and 2 are active from the earlier scenarios, all others idle
        rdc(REG_STATUS, 32'h0000_0005);
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        volt_in = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_no();
        t_nc_thr();
        t_dly();
        t_ac();
        t_out();
        final_report();
    end
endmodule
